// ===== hdl/eip_pkg.sv
package eip_pkg;

  // Special function register addresses
  localparam logic [7:0] EIP_MASK2_ADDR = 8'he7;
  localparam logic [7:0] EIP_PRIO2_ADDR = 8'hf7;
  localparam logic [7:0] EIP_CFG_ADDR = 8'he4;

  // Reset values
  localparam logic [7:0] EIP_CFG_RESET = 8'h01;
  localparam logic [3:0] EIP_NIBBLE_RESET = 4'h0;
  localparam logic [3:0] EIP_UNUSED_READ = 4'h0;
  localparam logic [7:0] EIP_READ_ZERO = 8'h00;

  // Source positions inside the mask and priority registers
  localparam int EIP_SRC_W = 4;
  localparam int EIP_SPI1_BIT = 3;
  localparam int EIP_RTCF_BIT = 2;
  localparam int EIP_MATCH_BIT = 1;
  localparam int EIP_WARN_BIT = 0;

  // Configuration register fields
  localparam int EIP_SEL_W = 3;
  localparam int EIP_A_SEL_LSB = 0;
  localparam int EIP_A_POL_BIT = 3;
  localparam int EIP_B_SEL_LSB = 4;
  localparam int EIP_B_POL_BIT = 7;

  // Timer control register bits owned by this block
  localparam int EIP_A_EDGE_BIT = 0;
  localparam int EIP_A_PEND_BIT = 1;
  localparam int EIP_B_EDGE_BIT = 2;
  localparam int EIP_B_PEND_BIT = 3;

  // Number of external inputs and port pins
  localparam int EIP_EXT_N = 2;
  localparam int EIP_PORT_W = 8;

  // Register access request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } eip_sfr_req_s;

  // Per-input detection setup
  typedef struct packed {
    logic polarity;
    logic edge_mode;
  } eip_ext_cfg_s;

  // Pick one port pin by its select code
  function automatic logic eip_sel_pin(input logic [EIP_PORT_W-1:0] pins,
                                       input logic [EIP_SEL_W-1:0] sel);
    eip_sel_pin = pins[sel];
  endfunction

endpackage

// ===== hdl/eip_ext_detect.sv
module eip_ext_detect
  import eip_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input eip_ext_cfg_s cfg_i,
  input wire logic ack_i,
  input wire logic sw_wr_i,
  input wire logic sw_pend_i,
  output logic pending_o
);

  logic pend_reg;
  logic pend_next;
  logic prev_reg;
  logic prev_next;
  logic active;
  logic edge_hit;

  // Polarity turns the pin into an active level
  assign active = cfg_i.polarity ? pin_i : ~pin_i;
  assign edge_hit = active & ~prev_reg;

  // Pending flag: follows level, or latches edges until cleared
  always_comb begin
    prev_next = active;
    pend_next = pend_reg;
    if (!cfg_i.edge_mode) begin
      pend_next = active;
    end else begin
      if (ack_i || (sw_wr_i && !sw_pend_i)) begin
        pend_next = 1'b0;
      end
      if (sw_wr_i && sw_pend_i) begin
        pend_next = 1'b1;
      end
      // A new edge beats a clear in the same cycle
      if (edge_hit) begin
        pend_next = 1'b1;
      end
    end
  end

  // Previous level resets high so reset release never fakes an edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
      prev_reg <= 1'b1;
    end else if (ce_i) begin
      pend_reg <= pend_next;
      prev_reg <= prev_next;
    end
  end

  assign pending_o = pend_reg;

  // Level mode flag tracks the active level one cycle later
  chk_level_follow: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ce_i && !cfg_i.edge_mode |=> pend_reg == $past(active))
    else $error("level pending does not follow input");

  // Edge mode sets the flag on the active edge
  chk_edge_set: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ce_i && cfg_i.edge_mode && active && !prev_reg |=> pend_reg)
    else $error("active edge did not set pending");

  // Vectoring clears an edge flag unless a new edge arrives
  chk_ack_clear: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ce_i && cfg_i.edge_mode && ack_i && !edge_hit && !sw_wr_i
    |=> !pend_reg)
    else $error("vector ack did not clear pending");

  cov_edge_pend: cover property (
    @(posedge clk_i) disable iff (srst_i)
    cfg_i.edge_mode && !pend_reg ##1 pend_reg ##[1:20] !pend_reg);

endmodule // eip_ext_detect

// ===== hdl/eip_top.sv
// Operation
// - Bits 7:4 of mask and priority registers read zero, writes ignored.
// - Mask bit 3 gates all second serial channel requests.
// - Mask bit 2 gates the clock oscillator fail request.
// - Mask bit 1 gates all port match requests.
// - Mask bit 0 gates the supply early warning request.
// - Priority bit 3 sets second serial channel priority, 1 high.
// - Priority bit 2 sets oscillator fail priority, 1 high.
// - Priority bit 1 sets port match priority, 1 high.
// - Priority bit 0 sets supply warning priority, 1 high.
// - Per input polarity (1 high) and sensing (1 edge, 0 level) bits.
// - Inputs only observe their pin, never disturbing the pin's owner.
// - Pending flags sit at timer control bits 1 and 3.
// - Edge mode sets pending on active edge, vectoring clears it.
// - Level mode pending follows the input's active level.
// - Three bit select picks port 0 pin 0 to 7.
// - Config resets polarity low, A selects pin 1, B pin 0.
module eip_top
  import eip_pkg::*;
#(
  parameter logic [7:0] TMR_CTRL_ADDR = 8'hbe
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input eip_sfr_req_s SFR_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_RVALID_O,
  input wire logic [EIP_PORT_W-1:0] PORT0_I,
  input wire logic [EIP_SRC_W-1:0] SRC_REQ_I,
  output logic [EIP_SRC_W-1:0] IRQ_REQ_O,
  output logic [EIP_SRC_W-1:0] IRQ_PRIO_O,
  input wire logic [EIP_EXT_N-1:0] EXT_ACK_I,
  output logic [EIP_EXT_N-1:0] EXT_PEND_O
);

  logic [EIP_SRC_W-1:0] mask_reg;
  logic [EIP_SRC_W-1:0] mask_next;
  logic [EIP_SRC_W-1:0] prio_reg;
  logic [EIP_SRC_W-1:0] prio_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [EIP_EXT_N-1:0] edge_reg;
  logic [EIP_EXT_N-1:0] edge_next;
  logic [EIP_SRC_W-1:0] req_reg;
  logic [EIP_SRC_W-1:0] req_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [EIP_PORT_W-1:0] sync1_reg;
  logic [EIP_PORT_W-1:0] sync2_reg;
  logic [EIP_EXT_N-1:0] pend;
  logic [EIP_EXT_N-1:0] sel_pin;
  logic [EIP_EXT_N-1:0] pol;
  logic [EIP_EXT_N-1:0] sw_pend;
  logic tmr_wr;

  // Register writes; unused upper bits are simply not stored
  always_comb begin
    mask_next = mask_reg;
    prio_next = prio_reg;
    cfg_next = cfg_reg;
    edge_next = edge_reg;
    if (SFR_I.wr) begin
      unique case (SFR_I.addr)
        EIP_MASK2_ADDR: mask_next = SFR_I.wdata[EIP_SRC_W-1:0];
        EIP_PRIO2_ADDR: prio_next = SFR_I.wdata[EIP_SRC_W-1:0];
        EIP_CFG_ADDR: cfg_next = SFR_I.wdata;
        TMR_CTRL_ADDR: begin
          edge_next[0] = SFR_I.wdata[EIP_A_EDGE_BIT];
          edge_next[1] = SFR_I.wdata[EIP_B_EDGE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Control registers; config carries its pin 1 default for input A
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      mask_reg <= EIP_NIBBLE_RESET;
      prio_reg <= EIP_NIBBLE_RESET;
      cfg_reg <= EIP_CFG_RESET;
      edge_reg <= '0;
    end else if (CE_I) begin
      mask_reg <= mask_next;
      prio_reg <= prio_next;
      cfg_reg <= cfg_next;
      edge_reg <= edge_next;
    end
  end

  // Read mux; anything unmapped reads zero
  always_comb begin
    rvalid_next = SFR_I.rd;
    rdata_next = rdata_reg;
    if (SFR_I.rd) begin
      unique case (SFR_I.addr)
        EIP_MASK2_ADDR: rdata_next = {EIP_UNUSED_READ, mask_reg};
        EIP_PRIO2_ADDR: rdata_next = {EIP_UNUSED_READ, prio_reg};
        EIP_CFG_ADDR: rdata_next = cfg_reg;
        TMR_CTRL_ADDR: begin
          rdata_next = EIP_READ_ZERO;
          rdata_next[EIP_A_EDGE_BIT] = edge_reg[0];
          rdata_next[EIP_A_PEND_BIT] = pend[0];
          rdata_next[EIP_B_EDGE_BIT] = edge_reg[1];
          rdata_next[EIP_B_PEND_BIT] = pend[1];
        end
        default: rdata_next = EIP_READ_ZERO;
      endcase
    end
  end

  // Enable gating; registered so outputs come from flops
  always_comb begin
    req_next = SRC_REQ_I & mask_reg;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rdata_reg <= EIP_READ_ZERO;
      rvalid_reg <= 1'b0;
      req_reg <= '0;
    end else if (CE_I) begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      req_reg <= req_next;
    end
  end

  // Two-stage pin synchroniser; pins are only ever read here
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (CE_I) begin
      sync1_reg <= PORT0_I;
      sync2_reg <= sync1_reg;
    end
  end

  // Pin selection after the synchroniser, so switching select is glitch-safe
  assign sel_pin[0] = eip_sel_pin(sync2_reg,
    cfg_reg[EIP_A_SEL_LSB +: EIP_SEL_W]);
  assign sel_pin[1] = eip_sel_pin(sync2_reg,
    cfg_reg[EIP_B_SEL_LSB +: EIP_SEL_W]);
  assign pol[0] = cfg_reg[EIP_A_POL_BIT];
  assign pol[1] = cfg_reg[EIP_B_POL_BIT];
  assign sw_pend[0] = SFR_I.wdata[EIP_A_PEND_BIT];
  assign sw_pend[1] = SFR_I.wdata[EIP_B_PEND_BIT];
  assign tmr_wr = SFR_I.wr && (SFR_I.addr == TMR_CTRL_ADDR);

  // One detector per external input
  for (genvar g = 0; g < EIP_EXT_N; g++) begin : g_ext
    eip_ext_cfg_s det_cfg;
    assign det_cfg = '{polarity: pol[g], edge_mode: edge_reg[g]};
    eip_ext_detect u_det (
      .clk_i(REF_CLK_I),
      .srst_i(SRST_I),
      .ce_i(CE_I),
      .pin_i(sel_pin[g]),
      .cfg_i(det_cfg),
      .ack_i(EXT_ACK_I[g]),
      .sw_wr_i(tmr_wr),
      .sw_pend_i(sw_pend[g]),
      .pending_o(pend[g])
    );
  end

  assign SFR_RDATA_O = rdata_reg;
  assign SFR_RVALID_O = rvalid_reg;
  assign IRQ_REQ_O = req_reg;
  assign IRQ_PRIO_O = prio_reg;
  assign EXT_PEND_O = pend;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  chk_unused_mask: assert property (
    CE_I && SFR_I.rd && SFR_I.addr == EIP_MASK2_ADDR
    |=> SFR_RDATA_O[7:4] == EIP_UNUSED_READ && SFR_RVALID_O)
    else $error("mask upper bits not zero");

  chk_prio_readback: assert property (
    CE_I && SFR_I.wr && SFR_I.addr == EIP_PRIO2_ADDR ##1
    CE_I && SFR_I.rd && SFR_I.addr == EIP_PRIO2_ADDR && !SFR_I.wr
    |=> SFR_RDATA_O == {EIP_UNUSED_READ, $past(SFR_I.wdata[3:0], 2)})
    else $error("priority readback wrong");

  chk_spi1_gate: assert property (
    CE_I && !mask_reg[EIP_SPI1_BIT] |=> !IRQ_REQ_O[EIP_SPI1_BIT])
    else $error("serial channel request leaked");

  chk_rtcf_pass: assert property (
    CE_I && mask_reg[EIP_RTCF_BIT] && SRC_REQ_I[EIP_RTCF_BIT]
    |=> IRQ_REQ_O[EIP_RTCF_BIT])
    else $error("oscillator fail request lost");

  chk_match_gate: assert property (
    CE_I |=> IRQ_REQ_O[EIP_MATCH_BIT] ==
    $past(SRC_REQ_I[EIP_MATCH_BIT] & mask_reg[EIP_MATCH_BIT]))
    else $error("port match gating wrong");

  chk_warn_gate: assert property (
    CE_I && !mask_reg[EIP_WARN_BIT] && SRC_REQ_I[EIP_WARN_BIT]
    |=> !IRQ_REQ_O[EIP_WARN_BIT])
    else $error("supply warning request leaked");

  chk_prio_write: assert property (
    CE_I && SFR_I.wr && SFR_I.addr == EIP_PRIO2_ADDR
    |=> IRQ_PRIO_O == $past(SFR_I.wdata[3:0]))
    else $error("priority write not applied");

  chk_cfg_reset: assert property (
    disable iff (1'b0) SRST_I |=> cfg_reg == EIP_CFG_RESET)
    else $error("config reset value wrong");

  chk_pend_read: assert property (
    CE_I && SFR_I.rd && SFR_I.addr == TMR_CTRL_ADDR
    |=> SFR_RDATA_O[EIP_A_PEND_BIT] == $past(pend[0]) &&
        SFR_RDATA_O[EIP_B_PEND_BIT] == $past(pend[1]))
    else $error("pending flags misplaced");

  cov_req_fwd: cover property (mask_reg[EIP_SPI1_BIT] ##1
    IRQ_REQ_O[EIP_SPI1_BIT]);
  cov_level_pend: cover property (!edge_reg[1] && pend[1] ##[1:20] !pend[1]);
  cov_sel_change: cover property (CE_I && SFR_I.wr &&
    SFR_I.addr == EIP_CFG_ADDR);

endmodule // eip_top

// ===== test/eip_src_model.sv
// Far side: port pins and the core's vectoring acknowledge
module eip_src_model (
  input wire logic clk_i,
  input wire logic [1:0] pend_i,
  output logic [7:0] port0_o,
  output logic [1:0] ack_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins high, so the active-low reset setup sees no request
  initial begin
    port0_o = 8'hff;
    ack_o = 2'b00;
  end

  // Skip bits assumed set, so only this model drives the pins
  task automatic set_pins(input logic [7:0] v);
    @(negedge clk_i);
    port0_o <= v;
  endtask

  // One cycle vector pulse
  task automatic pulse_ack(input logic [1:0] v);
    @(negedge clk_i);
    ack_o <= v;
    @(negedge clk_i);
    ack_o <= 2'b00;
  endtask

  // Level request: hold until seen, then drop before service ends
  task automatic level_req(input int pin, input int pb, input logic act,
                           output logic ok);
    int n;
    n = 0;
    @(negedge clk_i);
    port0_o[pin] <= act;
    @(negedge clk_i);
    while (pend_i[pb] !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    ok = pend_i[pb] === 1'b1;
    port0_o[pin] <= ~act;
  endtask
endmodule // eip_src_model

// ===== test/eip_top_tb_top.sv
module eip_top_tb_top;
  import eip_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] TMR = 8'hbe;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  eip_sfr_req_s sfr = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] port0;
  logic [3:0] src = 4'h0;
  logic [3:0] irq;
  logic [3:0] prio;
  logic [1:0] ack;
  logic [1:0] pend;
  logic ok;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  eip_top #(.TMR_CTRL_ADDR(TMR)) eip_top_i (
    .REF_CLK_I(ref_clk),
    .SRST_I(srst),
    .CE_I(ce),
    .SFR_I(sfr),
    .SFR_RDATA_O(rdata),
    .SFR_RVALID_O(rvalid),
    .PORT0_I(port0),
    .SRC_REQ_I(src),
    .IRQ_REQ_O(irq),
    .IRQ_PRIO_O(prio),
    .EXT_ACK_I(ack),
    .EXT_PEND_O(pend)
  );

  eip_src_model eip_src_model_i (
    .clk_i(ref_clk),
    .pend_i(pend),
    .port0_o(port0),
    .ack_o(ack)
  );

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk);
    sfr <= '0;
  endtask

  // Read waits a bounded time for the valid strobe
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge ref_clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk);
    sfr <= '0;
    while (rvalid !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    check(rvalid === 1'b1 ? rdata : ~exp, exp);
  endtask

  // Hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    srst <= 1'b0;
    sfr_rd(EIP_MASK2_ADDR, 8'h00);
    sfr_rd(EIP_PRIO2_ADDR, 8'h00);
    sfr_rd(EIP_CFG_ADDR, 8'h01);
    sfr_rd(TMR, 8'h00);
    sfr_rd(8'h55, 8'h00);
    // Upper nibble writes are dropped
    sfr_wr(EIP_MASK2_ADDR, 8'hf0);
    sfr_rd(EIP_MASK2_ADDR, 8'h00);
    src <= 4'hf;
    // One source enabled and raised in priority at a time
    for (int i = 0; i < 4; i++) begin
      sfr_wr(EIP_MASK2_ADDR, 8'hf0 | (8'h01 << i));
      sfr_wr(EIP_PRIO2_ADDR, 8'hf0 | (8'h01 << i));
      cyc(2);
      check({4'h0, irq}, 8'h01 << i);
      check({4'h0, prio}, 8'h01 << i);
      sfr_rd(EIP_PRIO2_ADDR, 8'h01 << i);
    end
    // Write then read in the very next cycle, upper nibble dropped
    @(negedge ref_clk);
    sfr <= '{addr: EIP_PRIO2_ADDR, wr: 1'b1, rd: 1'b0, wdata: 8'ha5};
    @(negedge ref_clk);
    sfr <= '{addr: EIP_PRIO2_ADDR, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk);
    sfr <= '0;
    check(rvalid === 1'b1 ? rdata : 8'hff, 8'h05);
    src <= 4'h0;
    cyc(2);
    check({4'h0, irq}, 8'h00);
    // Input A active high, level, every pin select code
    for (int s = 0; s < 8; s++) begin
      sfr_wr(EIP_CFG_ADDR, 8'h08 | 8'(s));
      eip_src_model_i.set_pins(8'h01 << s);
      cyc(5);
      check({7'h0, pend[0]}, 8'h01);
      eip_src_model_i.set_pins(~(8'h01 << s));
      cyc(5);
      check({7'h0, pend[0]}, 8'h00);
    end
    // Edge mode: A active low on pin 1, B active high on pin 0
    eip_src_model_i.set_pins(8'hfe);
    sfr_wr(EIP_CFG_ADDR, 8'h81);
    cyc(5);
    sfr_wr(TMR, 8'h05);
    eip_src_model_i.set_pins(8'hfc);
    cyc(5);
    check({6'h0, pend}, 8'h01);
    sfr_rd(TMR, 8'h07);
    eip_src_model_i.set_pins(8'hfe);
    cyc(5);
    check({6'h0, pend}, 8'h01);
    eip_src_model_i.pulse_ack(2'b01);
    check({6'h0, pend}, 8'h00);
    eip_src_model_i.set_pins(8'hff);
    cyc(5);
    check({6'h0, pend}, 8'h02);
    sfr_rd(TMR, 8'h0d);
    eip_src_model_i.pulse_ack(2'b01);
    check({6'h0, pend}, 8'h02);
    sfr_wr(TMR, 8'h05);
    cyc(1);
    check({6'h0, pend}, 8'h00);
    // Software sets both flags, then input B is vectored alone
    sfr_wr(TMR, 8'h0f);
    cyc(1);
    check({6'h0, pend}, 8'h03);
    eip_src_model_i.pulse_ack(2'b10);
    check({6'h0, pend}, 8'h01);
    // Level mode B, source holds then releases
    eip_src_model_i.set_pins(8'hfe);
    sfr_wr(TMR, 8'h00);
    cyc(5);
    eip_src_model_i.level_req(0, 1, 1'b1, ok);
    check({7'h0, ok}, 8'h01);
    cyc(5);
    check({6'h0, pend}, 8'h00);
    // Clock enable low: writes and pin changes must not be seen
    ce <= 1'b0;
    sfr_wr(EIP_MASK2_ADDR, 8'h0f);
    eip_src_model_i.set_pins(8'hff);
    cyc(5);
    check({6'h0, pend}, 8'h00);
    ce <= 1'b1;
    cyc(5);
    check({6'h0, pend}, 8'h02);
    sfr_rd(EIP_MASK2_ADDR, 8'h08);
    finish_test();
  end
endmodule // eip_top_tb_top
